//--- shared/mmt_consts.vh
// constants for the multi mode timer unit
`ifndef MMT_CONSTS_VH
`define MMT_CONSTS_VH

// ************************************************************
// channel counts and widths
// ************************************************************
`define MMT_A_CH        5
`define MMT_B_CH        6
`define MMT_CW          16
`define MMT_ZERO        16'h0000
`define MMT_ONES        16'hFFFF
`define MMT_ONE         16'h0001

// ************************************************************
// register map: region in addr[7:5], word index in addr[4:2]
// ************************************************************
`define MMT_RG_MISC     3'h0
`define MMT_RG_AMODE    3'h1
`define MMT_RG_ACNT     3'h2
`define MMT_RG_BMODE    3'h3
`define MMT_RG_BCNT     3'h4
`define MMT_IX_START1   3'h0
`define MMT_IX_START2   3'h1
`define MMT_IX_FLAGS    3'h2
`define MMT_IX_DIR      3'h3
`define MMT_IX_PRESC    3'h4

// ************************************************************
// fields
// ************************************************************
`define MMT_ST_B_HI     7
`define MMT_ST_B_LO     5
`define MMT_B_FLAG_LSB  5
`define MMT_ST_B_LSB    3
`define MMT_MD_EXTTRIG  2
`define MMT_MD_OVF      5
`define MMT_PRESC_RST   8'h00

// ************************************************************
// operating modes, mode field bits [1:0]
// ************************************************************
`define MMT_M_TIMER     2'h0
`define MMT_M_EVENT     2'h1
`define MMT_M_ONESHOT   2'h2
`define MMT_M_PWM       2'h3
`define MMT_M_PERIOD    2'h2
`define MMT_M_WIDTH     2'h3

`endif

//--- design/mmt_prescaler.v
// count source divider producing a one-cycle tick
`timescale 1ns/1ps
module mmt_prescaler #(
  parameter W = 8
) (
  // clock and reset
  input  wire         clk,
  input  wire         resetn,
  // divide setting, tick every divisor+1 clocks
  input  wire [W-1:0] divisor,
  // count source tick
  output reg          tickPulse
);
  reg [W-1:0] div_q;

  // ************************************************************
  // divider
  // ************************************************************
  // down counter reloads from divisor, so a new ratio applies at the next wrap
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      div_q     <= {W{1'b0}};
      tickPulse <= 1'b0;
    end else begin
      tickPulse <= (div_q == {W{1'b0}});
      if (div_q == {W{1'b0}}) begin
        div_q <= divisor;
      end else begin
        div_q <= div_q - {{(W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule // mmt_prescaler

//--- design/mmt_timer_unit.v
// multi mode timer unit: five group-a and six group-b channels behind apb
//
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`include "mmt_consts.vh"

// Operation
// - five group-a, six group-b channels, own start
// - all channels stopped after reset
// - timer read gives live count
// - stopped counter write reads back
// - event counter read gives live count
// - one-shot stop mid-pulse reloads, output low, flag
// - one-shot acts on count source tick
// - entering one-shot from timer/event sets flag
// - retrigger decrements once then reloads
// - entering pwm from timer/event sets flag
// - pwm stop: high goes low with flag
// - group-b start bits sit in bits 7:5
// - first measurement edge raises no request
// - measurement counter starts undefined, may overflow
// - changed measure select may set flag
// - width mode measures both levels alike
// - overflow with edge gives one request
module mmt_timer_unit #(
  parameter AW = 12,
  parameter PW = 8
) (
  // clock and reset
  input  wire          clk,
  input  wire          resetn,
  // apb slave
  input  wire          psel,
  input  wire          penable,
  input  wire          pwrite,
  input  wire [AW-1:0] paddr,
  input  wire [31:0]   pwdata,
  output reg  [31:0]   prdata,
  output reg           pready,
  output reg           pslverr,
  // pins
  input  wire [4:0]    groupAInputPin,
  input  wire [5:0]    groupBInputPin,
  output wire [4:0]    groupAOutputPin,
  // request flags toward interrupt controller, b in [10:5]
  output reg  [10:0]   requestFlag
);

  // ************************************************************
  // bus decode
  // ************************************************************
  wire [2:0]  region = paddr[7:5];
  wire [2:0]  idx    = paddr[4:2];
  wire        upZero = (paddr[AW-1:8] == {(AW-8){1'b0}}) && (paddr[1:0] == 2'b00);
  reg         hit;
  reg  [31:0] rdD;
  wire        wrEn   = psel & penable & pwrite & pready & hit;
  wire        setup  = psel & ~penable;
  wire        wrMisc = wrEn && region == `MMT_RG_MISC;

  // shared control registers
  reg  [4:0]    groupACountStart_q;
  reg  [5:0]    groupBCountStart_q;
  reg  [4:0]    startAPrev_q;
  reg  [5:0]    startBPrev_q;
  reg  [4:0]    countDirection_q;
  reg  [PW-1:0] presc_q;
  wire          tick;
  wire [4:0]    evA;
  wire [5:0]    evB;
  wire [16*5-1:0] aCntBus;
  wire [4*5-1:0]  aModeBus;
  wire [16*6-1:0] bRdBus;
  wire [6*6-1:0]  bModeBus;
  wire [4:0]      aOut;

  assign groupAOutputPin = aOut;

  // count source shared by all channels
  mmt_prescaler #(.W(PW)) uPresc (
    .clk       (clk),
    .resetn    (resetn),
    .divisor   (presc_q),
    .tickPulse (tick)
  );

  // ************************************************************
  // apb handshake
  // ************************************************************
  // one wait state: read data are registered in setup, answer in access
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~hit;
      if (setup) begin
        prdata <= rdD;
      end
    end
  end

  // read mux and unmapped detection
  always @* begin
    hit = 1'b0;
    rdD = 32'h0000_0000;
    case (region)
      `MMT_RG_MISC: begin
        hit = upZero && idx <= `MMT_IX_PRESC;
        case (idx)
          `MMT_IX_START1: rdD = {24'h00_0000, groupBCountStart_q[2:0], groupACountStart_q};
          `MMT_IX_START2: rdD = {24'h00_0000, groupBCountStart_q[5:3], 5'h00};
          `MMT_IX_FLAGS:  rdD = {21'h00_0000, requestFlag};
          `MMT_IX_DIR:    rdD = {27'h000_0000, countDirection_q};
          `MMT_IX_PRESC:  rdD = {{(32-PW){1'b0}}, presc_q};
          default:        rdD = 32'h0000_0000;
        endcase
      end
      `MMT_RG_AMODE: begin
        hit = upZero && idx < 3'd5;
        if (hit) rdD = {28'h000_0000, aModeBus[idx*4 +: 4]};
      end
      `MMT_RG_ACNT: begin
        hit = upZero && idx < 3'd5;
        if (hit) rdD = {16'h0000, aCntBus[idx*16 +: 16]};
      end
      `MMT_RG_BMODE: begin
        hit = upZero && idx < 3'd6;
        if (hit) rdD = {26'h000_0000, bModeBus[idx*6 +: 6]};
      end
      `MMT_RG_BCNT: begin
        hit = upZero && idx < 3'd6;
        if (hit) rdD = {16'h0000, bRdBus[idx*16 +: 16]};
      end
      default: begin
        hit = 1'b0;
        rdD = 32'h0000_0000;
      end
    endcase
  end

  // ************************************************************
  // start, direction, divider and request flags
  // ************************************************************
  // flags clear by writing one; a same-cycle event still sets
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      groupACountStart_q <= 5'h00;
      groupBCountStart_q <= 6'h00;
      startAPrev_q       <= 5'h00;
      startBPrev_q       <= 6'h00;
      countDirection_q   <= 5'h00;
      presc_q            <= `MMT_PRESC_RST;
      requestFlag        <= 11'h000;
    end else begin
      startAPrev_q <= groupACountStart_q;
      startBPrev_q <= groupBCountStart_q;
      if (wrMisc && idx == `MMT_IX_START1) begin
        groupACountStart_q      <= pwdata[4:0];
        groupBCountStart_q[2:0] <= pwdata[`MMT_ST_B_HI:`MMT_ST_B_LO];
      end
      if (wrMisc && idx == `MMT_IX_START2) begin
        groupBCountStart_q[5:3] <= pwdata[`MMT_ST_B_HI:`MMT_ST_B_LO];
      end
      if (wrMisc && idx == `MMT_IX_DIR) begin
        countDirection_q <= pwdata[4:0];
      end
      if (wrMisc && idx == `MMT_IX_PRESC) begin
        presc_q <= pwdata[PW-1:0];
      end
      if (wrMisc && idx == `MMT_IX_FLAGS) begin
        requestFlag <= (requestFlag & ~pwdata[10:0]) | {evB, evA};
      end else begin
        requestFlag <= requestFlag | {evB, evA};
      end
    end
  end

  // ************************************************************
  // group a channels
  // ************************************************************
  genvar ga;
  generate
    for (ga = 0; ga < `MMT_A_CH; ga = ga + 1) begin : gA
      reg  [15:0] cnt_q;
      reg  [15:0] rld_q;
      reg  [3:0]  mode_q;
      reg         busy_q;
      reg         out_q;
      reg         trig_q;
      reg         rtg_q;
      reg         inPrev_q;
      reg         ev_q;
      wire [1:0]  md      = mode_q[1:0];
      wire        go      = groupACountStart_q[ga];
      wire        stopNow = ~go & startAPrev_q[ga];
      wire        startNow = go & ~startAPrev_q[ga];
      wire        inRise  = groupAInputPin[ga] & ~inPrev_q;
      wire        oneTrig = mode_q[`MMT_MD_EXTTRIG] ? inRise : startNow;
      wire        cntZero = (cnt_q == `MMT_ZERO);
      wire        wrMode  = wrEn && region == `MMT_RG_AMODE && idx == ga;
      wire        wrCnt   = wrEn && region == `MMT_RG_ACNT && idx == ga;

      assign aCntBus[ga*16 +: 16] = cnt_q;
      assign aModeBus[ga*4 +: 4]  = mode_q;
      assign aOut[ga]             = out_q;
      assign evA[ga]              = ev_q;

      // channel engine; events register one clock after their cause
      always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          cnt_q    <= `MMT_ZERO;
          rld_q    <= `MMT_ZERO;
          mode_q   <= 4'h0;
          busy_q   <= 1'b0;
          out_q    <= 1'b0;
          trig_q   <= 1'b0;
          rtg_q    <= 1'b0;
          inPrev_q <= 1'b0;
          ev_q     <= 1'b0;
        end else begin
          inPrev_q <= groupAInputPin[ga];
          ev_q     <= 1'b0;
          // mode writes are expected while stopped, so no interlock here
          if (wrMode) begin
            mode_q <= pwdata[3:0];
            if (!md[1] && pwdata[1]) ev_q <= 1'b1;
          end
          if (wrCnt) begin
            rld_q <= pwdata[15:0];
            if (!go) cnt_q <= pwdata[15:0];
          end
          if (!go) begin
            trig_q <= 1'b0;
            rtg_q  <= 1'b0;
            if (stopNow && md == `MMT_M_ONESHOT && busy_q) begin
              busy_q <= 1'b0;
              out_q  <= 1'b0;
              cnt_q  <= rld_q;
              ev_q   <= 1'b1;
            end else if (stopNow && md == `MMT_M_PWM) begin
              busy_q <= 1'b0;
              out_q  <= 1'b0;
              if (out_q) ev_q <= 1'b1;
            end
          end else begin
            case (md)
              `MMT_M_TIMER: begin
                if (tick) begin
                  cnt_q <= cntZero ? rld_q : cnt_q - `MMT_ONE;
                  if (cntZero) ev_q <= 1'b1;
                end
              end
              `MMT_M_EVENT: begin
                if (inRise && countDirection_q[ga]) begin
                  cnt_q <= (cnt_q == `MMT_ONES) ? rld_q : cnt_q + `MMT_ONE;
                  if (cnt_q == `MMT_ONES) ev_q <= 1'b1;
                end else if (inRise) begin
                  cnt_q <= cntZero ? rld_q : cnt_q - `MMT_ONE;
                  if (cntZero) ev_q <= 1'b1;
                end
              end
              `MMT_M_ONESHOT: begin
                // trigger waits for the next tick, so at most one tick late
                if (oneTrig) trig_q <= 1'b1;
                if (rtg_q) begin
                  cnt_q <= rld_q;
                  rtg_q <= 1'b0;
                end else if (tick && trig_q && busy_q && !cntZero) begin
                  trig_q <= 1'b0;
                  cnt_q  <= cnt_q - `MMT_ONE;
                  rtg_q  <= 1'b1;
                end else if (tick && trig_q && !busy_q) begin
                  trig_q <= 1'b0;
                  busy_q <= 1'b1;
                  out_q  <= 1'b1;
                end else if (tick && busy_q && cntZero) begin
                  busy_q <= 1'b0;
                  out_q  <= 1'b0;
                  cnt_q  <= rld_q;
                  ev_q   <= 1'b1;
                end else if (tick && busy_q) begin
                  cnt_q <= cnt_q - `MMT_ONE;
                end
              end
              default: begin
                // pwm: high for reload+1 ticks, low for 65536 minus reload ticks
                if (startNow) begin
                  busy_q <= 1'b1;
                  out_q  <= 1'b1;
                  cnt_q  <= rld_q;
                end else if (tick && busy_q && cntZero) begin
                  out_q <= ~out_q;
                  cnt_q <= out_q ? ~rld_q : rld_q;
                  if (out_q) ev_q <= 1'b1;
                end else if (tick && busy_q) begin
                  cnt_q <= cnt_q - `MMT_ONE;
                end
              end
            endcase
          end
        end
      end
    end
  endgenerate

  // ************************************************************
  // group b channels
  // ************************************************************
  genvar gb;
  generate
    for (gb = 0; gb < `MMT_B_CH; gb = gb + 1) begin : gB
      reg  [15:0] cnt_q;
      reg  [15:0] rld_q;
      reg  [3:0]  mode_q;
      reg         ovf_q;
      reg         ovfAged_q;
      reg         seen_q;
      reg         inPrev_q;
      reg         ev_q;
      wire [1:0]  md      = mode_q[1:0];
      wire        meas    = md[1];
      wire        go      = groupBCountStart_q[gb];
      wire        inRise  = groupBInputPin[gb] & ~inPrev_q;
      wire        inFall  = ~groupBInputPin[gb] & inPrev_q;
      // width mode takes both edges and keeps no level tag
      wire        edgeOk  = (md == `MMT_M_WIDTH) ? (inRise | inFall) :
                            (mode_q[2] ? inFall : inRise);
      wire        cntZero = (cnt_q == `MMT_ZERO);
      wire        ovfNow  = tick && cnt_q == `MMT_ONES;
      wire        wrMode  = wrEn && region == `MMT_RG_BMODE && idx == gb;
      wire        wrCnt   = wrEn && region == `MMT_RG_BCNT && idx == gb;

      assign bRdBus[gb*16 +: 16] = meas ? rld_q : cnt_q;
      assign bModeBus[gb*6 +: 6] = {ovf_q, 1'b0, mode_q};
      assign evB[gb]             = ev_q;

      // channel engine; measurement counts up from whatever it holds
      always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          cnt_q     <= `MMT_ZERO;
          rld_q     <= `MMT_ZERO;
          mode_q    <= 4'h0;
          ovf_q     <= 1'b0;
          ovfAged_q <= 1'b0;
          seen_q    <= 1'b0;
          inPrev_q  <= 1'b0;
          ev_q      <= 1'b0;
        end else begin
          inPrev_q <= groupBInputPin[gb];
          ev_q     <= 1'b0;
          if (ovf_q && tick) ovfAged_q <= 1'b1;
          if (wrMode) begin
            mode_q <= pwdata[3:0];
            if (go && pwdata[3:2] != mode_q[3:2]) ev_q <= 1'b1;
            // a fresh overflow survives a clear until one tick has passed
            if (!go || ovfAged_q) begin
              ovf_q     <= 1'b0;
              ovfAged_q <= 1'b0;
            end
          end
          if (wrCnt) begin
            rld_q <= pwdata[15:0];
            if (!go) cnt_q <= pwdata[15:0];
          end
          if (!go) begin
            seen_q <= 1'b0;
          end else if (meas) begin
            if (ovfNow) begin
              cnt_q <= `MMT_ZERO;
              ovf_q <= 1'b1;
              ev_q  <= 1'b1;
            end else if (edgeOk) begin
              rld_q  <= cnt_q;
              cnt_q  <= `MMT_ZERO;
              seen_q <= 1'b1;
              if (seen_q) ev_q <= 1'b1;
            end else if (tick) begin
              cnt_q <= cnt_q + `MMT_ONE;
            end
          end else if ((md == `MMT_M_TIMER && tick) || (md == `MMT_M_EVENT && inRise)) begin
            cnt_q <= cntZero ? rld_q : cnt_q - `MMT_ONE;
            if (cntZero) ev_q <= 1'b1;
          end
        end
      end
    end
  endgenerate
endmodule // mmt_timer_unit

//--- dv/mmt_pin_model.sv
// pin-side partner model driving trigger and measurement inputs
`timescale 1ns/1ps
module mmt_pin_model (
  // clock
  input  wire        clk,
  // pins toward the timer unit
  output logic [4:0] groupAInputPin,
  output logic [5:0] groupBInputPin
);
  // ************************************************************
  // idle levels and pulse task
  // ************************************************************
  // pins rest low between pulses, never left floating
  initial begin
    groupAInputPin = 5'h00;
    groupBInputPin = 6'h00;
  end

  // one short high pulse, then a quiet gap of three clocks before the next edge
  task automatic pulse(input logic grpB, input int ch);
    @(posedge clk);
    if (grpB) groupBInputPin[ch] <= 1'b1;
    else groupAInputPin[ch] <= 1'b1;
    repeat (3) @(posedge clk);
    if (grpB) groupBInputPin[ch] <= 1'b0;
    else groupAInputPin[ch] <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
endmodule // mmt_pin_model

//--- dv/mmt_timer_unit_sva.sv
// checker on the timer unit ports, bound at the foot of the file
`timescale 1ns/1ps
module mmt_timer_unit_sva (
  // clock and reset
  input wire        clk,
  input wire        resetn,
  // apb
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  // pins and flags
  input wire [4:0]  groupAOutputPin,
  input wire [10:0] requestFlag
);
  // ************************************************************
  // properties, one clock, quiet during reset
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // everything stopped and clear as reset lets go
  property p_reset_quiet;
    $rose(resetn) |-> requestFlag == 11'h000 && groupAOutputPin == 5'h00;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("outputs not clear after reset");

  // exactly one wait state in every access
  property p_one_wait;
    psel && penable && !$past(penable) |-> !pready ##1 pready;
  endproperty
  a_one_wait: assert property (p_one_wait)
    else $error("access did not finish after one wait state");

  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("pready stood longer than one cycle");

  property p_ready_access;
    pready |-> psel && penable;
  endproperty
  a_ready_access: assert property (p_ready_access)
    else $error("pready outside an access phase");

  property p_err_ready;
    pslverr |-> pready;
  endproperty
  a_err_ready: assert property (p_err_ready)
    else $error("pslverr without pready");

  // read data is latched at setup, so it must not move in the access phase
  property p_read_hold;
    pready && !pwrite |-> $stable(prdata);
  endproperty
  a_read_hold: assert property (p_read_hold)
    else $error("read data moved during access");

  property p_read_upper;
    pready && !pwrite |-> prdata[31:16] == 16'h0000;
  endproperty
  a_read_upper: assert property (p_read_upper)
    else $error("read data wider than sixteen bits");

  // flags are sticky: they drop only after a completed write
  property p_flag_sticky;
    |($past(requestFlag) & ~requestFlag) |-> $past(pready) && $past(pwrite);
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("request flag dropped without a write");

  // every falling pulse output is followed by its request flag
  genvar g;
  for (g = 0; g < 5; g = g + 1) begin : gFall
    property p_fall_flag;
      $fell(groupAOutputPin[g]) |-> ##[0:3] requestFlag[g];
    endproperty
    a_fall_flag: assert property (p_fall_flag)
      else $error("output fell without a request flag");
  end
endmodule // mmt_timer_unit_sva

bind mmt_timer_unit mmt_timer_unit_sva u_sva (
  .clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .groupAOutputPin(groupAOutputPin), .requestFlag(requestFlag)
);

//--- dv/tb_top.sv
// self-checking bench for the multi mode timer unit
`timescale 1ns/1ps
module tb_top;
  typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] e;} mmt_row_t;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  wire  [31:0] prdata;
  wire         pready;
  wire         pslverr;
  wire  [4:0]  groupAInputPin;
  wire  [5:0]  groupBInputPin;
  wire  [4:0]  groupAOutputPin;
  wire  [10:0] requestFlag;
  int          fails = 0;
  int          num_checks = 0;
  logic [31:0] rd;
  logic        err;
  // counters written while stopped, start bits, direction, upper bits dropped
  mmt_row_t    rows [8] = '{'{12'h040, 32'h0001_1234, 32'h0000_1234}, '{12'h050, 32'h0000_FFFF, 32'h0000_FFFF},
                            '{12'h080, 32'h0000_BEEF, 32'h0000_BEEF}, '{12'h00C, 32'h0000_00FF, 32'h0000_001F},
                            '{12'h004, 32'h0000_00FF, 32'h0000_00E0}, '{12'h004, 32'h0000_0000, 32'h0000_0000},
                            '{12'h000, 32'h0000_00FF, 32'h0000_00FF}, '{12'h000, 32'h0000_0000, 32'h0000_0000}};

  // ************************************************************
  // clock, design and pin partner
  // ************************************************************
  always #2.5 clk = ~clk;

  mmt_timer_unit dut (
    .clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .groupAInputPin(groupAInputPin),
    .groupBInputPin(groupBInputPin), .groupAOutputPin(groupAOutputPin), .requestFlag(requestFlag)
  );
  mmt_pin_model pm (.clk(clk), .groupAInputPin(groupAInputPin), .groupBInputPin(groupBInputPin));

  // ************************************************************
  // tasks
  // ************************************************************
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chkb(input string name, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %b seen %b", name, exp, got);
    end
  endtask

  // one apb transfer; request held until pready is seen, then a clock passes
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // no cycle limit here: only the watchdog ends a wait
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdw(input logic [11:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ************************************************************
  // sequence
  // ************************************************************
  // hang guard, well beyond the few hundred cycles the tests need
  initial begin
    #40000;
    fails++;
    end_of_test();
  end

  initial begin
    settle(4);
    resetn <= 1'b1;
    @(posedge clk);
    chk("flags", 32'h0, {21'h0, requestFlag});
    chk("outs", 32'h0, {27'h0, groupAOutputPin});
    rdw(12'h000);
    chk("start1", 32'h0, rd);
    rdw(12'h004);
    chk("start2", 32'h0, rd);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rdw(rows[i].a);
      chk("row", rows[i].e, rd);
    end
    // unmapped places refuse and read zero
    wr(12'h100, 32'h0000_FFFF);
    chkb("wrerr", 1'b1, err);
    rdw(12'h000);
    chk("wrignored", 32'h0, rd);
    rdw(12'h0A0);
    chkb("rderr", 1'b1, err);
    chk("rdzero", 32'h0, rd);
    // entering one-shot and pwm from timer flags; staying in one-shot does not
    settle(4);
    wr(12'h008, 32'h0000_07FF);
    wr(12'h020, 32'h0000_0002);
    wr(12'h024, 32'h0000_0003);
    settle(4);
    chk("modeflag", 32'h3, {30'h0, requestFlag[1:0]});
    wr(12'h008, 32'h0000_07FF);
    wr(12'h020, 32'h0000_0002);
    settle(4);
    chkb("sameflag", 1'b0, requestFlag[0]);
    // one-shot stopped mid-count: reload, output low, flag
    wr(12'h040, 32'h0000_0100);
    wr(12'h000, 32'h0000_0001);
    settle(8);
    chkb("osbusy", 1'b1, groupAOutputPin[0]);
    wr(12'h000, 32'h0000_0000);
    settle(3);
    chkb("osout", 1'b0, groupAOutputPin[0]);
    chkb("osflag", 1'b1, requestFlag[0]);
    rdw(12'h040);
    chk("osreload", 32'h0000_0100, rd);
    // pwm stopped while high goes low with flag
    wr(12'h044, 32'h0000_0040);
    wr(12'h008, 32'h0000_07FF);
    wr(12'h000, 32'h0000_0002);
    settle(4);
    chkb("pwmhigh", 1'b1, groupAOutputPin[1]);
    wr(12'h000, 32'h0000_0000);
    settle(3);
    chkb("pwmout", 1'b0, groupAOutputPin[1]);
    chkb("pwmflag", 1'b1, requestFlag[1]);
    // external trigger one-shot with a retrigger stretching the pulse
    wr(12'h028, 32'h0000_0006);
    wr(12'h048, 32'h0000_0080);
    wr(12'h008, 32'h0000_07FF);
    wr(12'h000, 32'h0000_0004);
    settle(4);
    chkb("waittrig", 1'b0, groupAOutputPin[2]);
    pm.pulse(1'b0, 2);
    chkb("trigout", 1'b1, groupAOutputPin[2]);
    settle(14);
    pm.pulse(1'b0, 2);
    settle(115);
    chkb("retrig", 1'b1, groupAOutputPin[2]);
    settle(30);
    chkb("osend", 1'b0, groupAOutputPin[2]);
    chkb("osendflag", 1'b1, requestFlag[2]);
    wr(12'h000, 32'h0000_0000);
    // period measurement: first edge silent, second edge flags
    wr(12'h060, 32'h0000_0002);
    wr(12'h008, 32'h0000_07FF);
    wr(12'h000, 32'h0000_0020);
    pm.pulse(1'b1, 0);
    chkb("firstedge", 1'b0, requestFlag[5]);
    pm.pulse(1'b1, 0);
    chkb("secondedge", 1'b1, requestFlag[5]);
    // same select written back keeps the flag clear, a new one may set it
    wr(12'h008, 32'h0000_07FF);
    wr(12'h060, 32'h0000_0002);
    settle(4);
    chkb("samesel", 1'b0, requestFlag[5]);
    wr(12'h060, 32'h0000_0006);
    settle(4);
    chkb("newsel", 1'b1, requestFlag[5]);
    // event counter counts pin edges up; measurement overflow flags, then clears
    wr(12'h04C, 32'h0000_0010);
    wr(12'h02C, 32'h0000_0001);
    wr(12'h084, 32'h0000_FFF0);
    wr(12'h064, 32'h0000_0002);
    wr(12'h000, 32'h0000_0048);
    pm.pulse(1'b0, 3);
    pm.pulse(1'b0, 3);
    rdw(12'h04C);
    chk("evcount", 32'h0000_0012, rd);
    rdw(12'h064);
    chk("ovfset", 32'h0000_0022, rd);
    chkb("ovfflag", 1'b1, requestFlag[6]);
    wr(12'h064, 32'h0000_0002);
    rdw(12'h064);
    chk("ovfclr", 32'h0000_0002, rd);
    end_of_test();
  end
endmodule // tb_top
